// *** hdl/fcpu_chan.sv ***
// Purpose: one output channel: compare stage, inversion, output flop
// Assumes: counter and reload strobe come from the shared counter
// Notes: output flop takes the reset-high level after reset
`timescale 1ns/1ps
module fcpu_chan #(
	parameter int CNT_W = 10
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_sync_b,
	input  wire logic             clk_en,
	input  wire logic             reset_high_select,
	input  wire logic             load_now,
	input  wire logic [CNT_W-1:0] cmp_buf,
	input  wire logic [CNT_W-1:0] count,
	input  wire logic             invert,
	output logic                  pwm_out
);
	logic [CNT_W-1:0] cmp_act_q;
	logic             init_q;
	logic             raw;

	// compare value reaches the active stage only at a reload
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cmp_act_q <= fcpu_pkg::CMP_RST;
		end else if (clk_en && load_now) begin
			cmp_act_q <= cmp_buf;
		end
	end

	// all ones compare is forced low so it never matches the counter top
	assign raw = (cmp_act_q == {CNT_W{1'b1}}) ? 1'b0 :
	             !(cmp_act_q > count);

	// the strap level is caught after release, not under the reset
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			init_q  <= 1'b1;
			pwm_out <= 1'b0;
		end else if (clk_en) begin
			if (init_q) begin
				init_q  <= 1'b0;
				pwm_out <= reset_high_select;
			end else begin
				pwm_out <= raw ^ invert;
			end
		end
	end
endmodule

// *** hdl/fcpu_pkg.sv ***
// Purpose: shared constants for the four channel pulse width unit
// Assumes: axi4-lite register access, 32-bit data, one word per register
// Notes: registers are kept as indices; byte address is four times the index
//
// Functional notes
// - one shared 10-bit down counter, decremented once per clock
// - on underflow the counter reloads from the active period value
// - rate is clock over period plus one; period split high/low
// - each underflow sets flag bit 5; it stays until software clears it
// - period loads only when run, load and underflow are all one
// - with load bit 6 clear, written values stay in their buffers
// - load bit clears itself the cycle after the transfer
// - writing one to bit 4 forces counter to zero; bit self-clears
// - uninverted output low while compare exceeds counter or is all ones, high otherwise
// - write compare, set load; new compare takes effect at next underflow
// - high time lasts period minus compare plus one counter clocks
// - compare zero holds output high; compare all ones holds it low
// - after reset each internal output takes the reset-high select level
// - run bit 7 zero stops the counter, one lets it run
// - control bits 3..0 invert channel 3..0 outputs when set
// - four channels, each with own 10-bit compare, one shared counter
package fcpu_pkg;
	localparam int CNT_W  = 10;
	localparam int CH_N   = 4;
	localparam int ADDR_W = 12;
	// ==========================================================
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_PER_HI  = 8'hD1;
	localparam logic [7:0] IDX_CH0_HI  = 8'hD2;
	localparam logic [7:0] IDX_CH1_HI  = 8'hD3;
	localparam logic [7:0] IDX_CH2_HI  = 8'hD5;
	localparam logic [7:0] IDX_CH3_HI  = 8'hD6;
	localparam logic [7:0] IDX_PER_LO  = 8'hD9;
	localparam logic [7:0] IDX_CH0_LO  = 8'hDA;
	localparam logic [7:0] IDX_CH1_LO  = 8'hDB;
	localparam logic [7:0] IDX_CTRL    = 8'hDC;
	localparam logic [7:0] IDX_CH2_LO  = 8'hDD;
	localparam logic [7:0] IDX_CH3_LO  = 8'hDE;
	localparam logic [7:0] IDX_IRQ_ST  = 8'hE0;
	localparam logic [7:0] IDX_IRQ_MSK = 8'hE1;
	localparam logic [7:0] IDX_COUNT   = 8'hE2;
	// ==========================================================
	// control register fields
	localparam int CTRL_RUN   = 7;
	localparam int CTRL_LOAD  = 6;
	localparam int CTRL_UFL   = 5;
	localparam int CTRL_CLR   = 4;
	localparam int CTRL_INV_W = 4;
	// interrupt status bits
	localparam int IRQ_UFL  = 0;
	localparam int IRQ_XFER = 1;
	localparam int IRQ_W    = 2;
	// ==========================================================
	// reset values and bus response codes
	localparam logic [7:0] CTRL_RST      = 8'h00;
	localparam logic [9:0] PER_RST       = 10'h3FF;
	localparam logic [9:0] CMP_RST       = 10'h000;
	localparam logic [9:0] CNT_CLR_VALUE = 10'h000;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

// *** hdl/fcpu_rst_sync.sv ***
// Purpose: release the active-low reset through two flip-flops
// Assumes: rst_b may be asynchronous to clk_sys
// Notes: assertion is immediate, release is after two edges
`timescale 1ns/1ps
module fcpu_rst_sync (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	output logic      rst_sync_b
);
	logic meta_q;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta_q     <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			meta_q     <= 1'b1;
			rst_sync_b <= meta_q;
		end
	end
endmodule

// *** hdl/fcpu_top.sv ***
// Purpose: four channel pulse width unit with axi4-lite registers
// Assumes: all inputs but rst_b synchronous to clk_sys; one access of each kind
// Notes: registers are 8 bits wide in the low lanes, upper bits read 0
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module fcpu_top #(
	parameter int CNT_W = 10,
	parameter int CH_N  = 4
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rst_b,
	input  wire logic                        clk_en,
	input  wire logic                        reset_high_select,
	input  wire logic [fcpu_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [fcpu_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic [CH_N-1:0]                  pwm_out,
	output logic                             irq
);
	// ==========================================================
	// reset
	logic rst_sync_b;

	fcpu_rst_sync u_rst (
		.clk_sys    (clk_sys),
		.rst_b      (rst_b),
		.rst_sync_b (rst_sync_b)
	);

	// ==========================================================
	// register state
	logic [CNT_W-1:0]            period_buf_q;
	logic [CNT_W-1:0]            period_act_q;
	logic [CH_N-1:0][CNT_W-1:0]  cmp_buf_q;
	logic                        run_q;
	logic                        load_q;
	logic                        ufl_q;
	logic                        clr_q;
	logic [CH_N-1:0]             inv_q;
	logic [CNT_W-1:0]            count_q;
	logic [fcpu_pkg::IRQ_W-1:0]  irq_st_q;
	logic [fcpu_pkg::IRQ_W-1:0]  irq_msk_q;

	// ==========================================================
	// write channel: address and data are latched independently
	logic [fcpu_pkg::ADDR_W-1:0] aw_addr_q;
	logic                        aw_have_q;
	logic [7:0]                  w_data_q;
	logic                        w_lane_q;
	logic                        w_have_q;
	logic                        wr_fire;
	logic [7:0]                  wr_idx;
	logic [7:0]                  wd;
	logic                        wr_ok;

	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_idx  = aw_addr_q[9:2];
	assign wd      = w_data_q;

	function automatic logic idx_mapped(input logic [7:0] idx,
	                                    input logic [1:0] low);
		logic hit;
		hit = 1'b0;
		case (idx)
			fcpu_pkg::IDX_PER_HI, fcpu_pkg::IDX_PER_LO,
			fcpu_pkg::IDX_CH0_HI, fcpu_pkg::IDX_CH0_LO,
			fcpu_pkg::IDX_CH1_HI, fcpu_pkg::IDX_CH1_LO,
			fcpu_pkg::IDX_CH2_HI, fcpu_pkg::IDX_CH2_LO,
			fcpu_pkg::IDX_CH3_HI, fcpu_pkg::IDX_CH3_LO,
			fcpu_pkg::IDX_CTRL, fcpu_pkg::IDX_IRQ_ST,
			fcpu_pkg::IDX_IRQ_MSK, fcpu_pkg::IDX_COUNT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit && (low == 2'h0);
	endfunction

	// the write takes effect only when lane 0 is strobed
	assign wr_ok = idx_mapped(wr_idx, aw_addr_q[1:0]) &&
	               (aw_addr_q[fcpu_pkg::ADDR_W-1:10] == '0);

	// ready falls a cycle after each offer so a held valid is not taken twice
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			aw_have_q     <= 1'b0;
			aw_addr_q     <= '0;
			s_axi_awready <= 1'b0;
		end else if (clk_en) begin
			s_axi_awready <= !aw_have_q && !s_axi_awready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
			end
		end
	end

	// data may come before or after the address; each waits in its holder
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			w_have_q     <= 1'b0;
			w_data_q     <= '0;
			w_lane_q     <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (clk_en) begin
			s_axi_wready <= !w_have_q && !s_axi_wready;
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q     <= 1'b1;
				w_data_q     <= s_axi_wdata[7:0];
				w_lane_q     <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= fcpu_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? fcpu_pkg::RESP_OKAY
				                      : fcpu_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic wr_en;
	assign wr_en = wr_fire && wr_ok && w_lane_q;

	function automatic logic wr_to(input logic [7:0] idx);
		return wr_en && (wr_idx == idx);
	endfunction

	// ==========================================================
	// counter core
	logic underflow;
	logic load_now;

	// the counter only counts while running, so no event fires when stopped
	assign underflow = run_q && !clr_q && (count_q == '0);
	assign load_now  = underflow && load_q;

	// a clear wins over counting, so no underflow fires in the clearing cycle
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			count_q      <= fcpu_pkg::CNT_CLR_VALUE;
			period_act_q <= fcpu_pkg::PER_RST;
		end else if (clk_en) begin
			if (clr_q) begin
				count_q <= fcpu_pkg::CNT_CLR_VALUE;
			end else if (run_q) begin
				if (count_q == '0) begin
					// reload with the freshly taken period when loading
					count_q <= load_q ? period_buf_q
					                  : period_act_q;
				end else begin
					count_q <= count_q - 1'b1;
				end
			end
			if (load_now) begin
				period_act_q <= period_buf_q;
			end
		end
	end

	// ==========================================================
	// period and compare buffers
	// halves may be written in any order; only a load makes them live
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			period_buf_q <= fcpu_pkg::PER_RST;
		end else if (clk_en) begin
			if (wr_to(fcpu_pkg::IDX_PER_HI)) begin
				period_buf_q[9:8] <= wd[1:0];
			end
			if (wr_to(fcpu_pkg::IDX_PER_LO)) begin
				period_buf_q[7:0] <= wd;
			end
		end
	end

	localparam logic [CH_N-1:0][7:0] HI_IDX = {fcpu_pkg::IDX_CH3_HI,
		fcpu_pkg::IDX_CH2_HI, fcpu_pkg::IDX_CH1_HI, fcpu_pkg::IDX_CH0_HI};
	localparam logic [CH_N-1:0][7:0] LO_IDX = {fcpu_pkg::IDX_CH3_LO,
		fcpu_pkg::IDX_CH2_LO, fcpu_pkg::IDX_CH1_LO, fcpu_pkg::IDX_CH0_LO};

	for (genvar c = 0; c < CH_N; c++) begin : g_ch
		always_ff @(posedge clk_sys or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				cmp_buf_q[c] <= fcpu_pkg::CMP_RST;
			end else if (clk_en) begin
				if (wr_to(HI_IDX[c])) begin
					cmp_buf_q[c][9:8] <= wd[1:0];
				end
				if (wr_to(LO_IDX[c])) begin
					cmp_buf_q[c][7:0] <= wd;
				end
			end
		end

		fcpu_chan #(
			.CNT_W (CNT_W)
		) u_chan (
			.clk_sys           (clk_sys),
			.rst_sync_b        (rst_sync_b),
			.clk_en            (clk_en),
			.reset_high_select (reset_high_select),
			.load_now          (load_now),
			.cmp_buf           (cmp_buf_q[c]),
			.count             (count_q),
			.invert            (inv_q[c]),
			.pwm_out           (pwm_out[c])
		);
	end

	// ==========================================================
	// control register
	logic ctrl_wr;
	assign ctrl_wr = wr_to(fcpu_pkg::IDX_CTRL);

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			run_q <= fcpu_pkg::CTRL_RST[fcpu_pkg::CTRL_RUN];
			load_q <= fcpu_pkg::CTRL_RST[fcpu_pkg::CTRL_LOAD];
			ufl_q <= fcpu_pkg::CTRL_RST[fcpu_pkg::CTRL_UFL];
			clr_q <= fcpu_pkg::CTRL_RST[fcpu_pkg::CTRL_CLR];
			inv_q <= fcpu_pkg::CTRL_RST[CH_N-1:0];
		end else if (clk_en) begin
			if (ctrl_wr) begin
				run_q <= wd[fcpu_pkg::CTRL_RUN];
				inv_q <= wd[CH_N-1:0];
			end
			// a load write in the transfer cycle re-arms, so it is not lost
			if (ctrl_wr) begin
				load_q <= wd[fcpu_pkg::CTRL_LOAD];
			end else if (load_now) begin
				load_q <= 1'b0;
			end
			clr_q <= ctrl_wr && wd[fcpu_pkg::CTRL_CLR];
			// underflow in the clearing cycle wins over software
			if (underflow) begin
				ufl_q <= 1'b1;
			end else if (ctrl_wr && !wd[fcpu_pkg::CTRL_UFL]) begin
				ufl_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// interrupt status and mask
	logic [fcpu_pkg::IRQ_W-1:0] irq_ev;
	assign irq_ev = {load_now, underflow};
	// irq trails the status bits by a cycle as it comes from a flop

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			irq_st_q  <= '0;
			irq_msk_q <= '0;
			irq       <= 1'b0;
		end else if (clk_en) begin
			irq_st_q <= irq_ev | (irq_st_q &
			            ~(wr_to(fcpu_pkg::IDX_IRQ_ST) ?
			              wd[fcpu_pkg::IRQ_W-1:0] : '0));
			if (wr_to(fcpu_pkg::IDX_IRQ_MSK)) begin
				irq_msk_q <= wd[fcpu_pkg::IRQ_W-1:0];
			end
			irq <= |(irq_st_q & irq_msk_q);
		end
	end

	// ==========================================================
	// read channel
	logic [7:0] rd_idx;
	logic [7:0] rd_val;
	assign rd_idx = s_axi_araddr[9:2];

	// a refused read answers zero so no register leaks through a bad address
	logic rd_ok;
	assign rd_ok = idx_mapped(rd_idx, s_axi_araddr[1:0]) &&
	               (s_axi_araddr[fcpu_pkg::ADDR_W-1:10] == '0);

	always_comb begin
		rd_val = 8'h00;
		case (rd_idx)
			fcpu_pkg::IDX_PER_HI:  rd_val = {6'h00, period_buf_q[9:8]};
			fcpu_pkg::IDX_PER_LO:  rd_val = period_buf_q[7:0];
			fcpu_pkg::IDX_CH0_HI:  rd_val = {6'h00, cmp_buf_q[0][9:8]};
			fcpu_pkg::IDX_CH0_LO:  rd_val = cmp_buf_q[0][7:0];
			fcpu_pkg::IDX_CH1_HI:  rd_val = {6'h00, cmp_buf_q[1][9:8]};
			fcpu_pkg::IDX_CH1_LO:  rd_val = cmp_buf_q[1][7:0];
			fcpu_pkg::IDX_CH2_HI:  rd_val = {6'h00, cmp_buf_q[2][9:8]};
			fcpu_pkg::IDX_CH2_LO:  rd_val = cmp_buf_q[2][7:0];
			fcpu_pkg::IDX_CH3_HI:  rd_val = {6'h00, cmp_buf_q[3][9:8]};
			fcpu_pkg::IDX_CH3_LO:  rd_val = cmp_buf_q[3][7:0];
			fcpu_pkg::IDX_CTRL:    rd_val = {run_q, load_q, ufl_q, clr_q,
			                                 inv_q};
			fcpu_pkg::IDX_IRQ_ST:  rd_val = {6'h00, irq_st_q};
			fcpu_pkg::IDX_IRQ_MSK: rd_val = {6'h00, irq_msk_q};
			fcpu_pkg::IDX_COUNT:   rd_val = count_q[7:0];
			default:               rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= fcpu_pkg::RESP_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_ok ? {24'h000000, rd_val} : 32'h0;
				s_axi_rresp   <= rd_ok ? fcpu_pkg::RESP_OKAY
				                       : fcpu_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// *** test/fcpu_load_model.sv ***
// Purpose: loads on the four pulse outputs, timing each period
// Assumes: outputs are levels sampled on clk_sys
// Notes: the first period after a change is not meaningful
`timescale 1ns/1ps
module fcpu_load_model #(
	parameter int CH_N = 4
) (
	input  wire logic            clk_sys,
	input  wire logic [CH_N-1:0] pwm_out,
	output int                   per_len [CH_N]
);
	logic [CH_N-1:0] prev_q;
	int              run_q [CH_N];
	// a load sees only its pin: period runs from rise to rise
	always_ff @(posedge clk_sys) begin
		prev_q <= pwm_out;
		for (int i = 0; i < CH_N; i++) begin
			if (pwm_out[i] && !prev_q[i]) begin
				per_len[i] <= run_q[i];
				run_q[i] <= 1;
			end else begin
				run_q[i] <= run_q[i] + 1;
			end
		end
	end
endmodule

// *** test/fcpu_top_sva.sv ***
// Purpose: port timing checks on the pulse width unit
// Assumes: one clock domain, active-low reset
// Notes: pwm levels are judged by the bench, here only timing and the level after reset
`timescale 1ns/1ps
module fcpu_top_chk #(
	parameter int CH_N = 4
) (
	input wire logic [0:0]      clk_sys,
	input wire logic [0:0]      rst_b,
	input wire logic [0:0]      clk_en,
	input wire logic [0:0]      reset_high_select,
	input wire logic [0:0]      s_axi_awvalid,
	input wire logic [0:0]      s_axi_awready,
	input wire logic [0:0]      s_axi_bvalid,
	input wire logic [0:0]      s_axi_bready,
	input wire logic [11:0]     s_axi_araddr,
	input wire logic [0:0]      s_axi_arvalid,
	input wire logic [0:0]      s_axi_arready,
	input wire logic [31:0]     s_axi_rdata,
	input wire logic [1:0]      s_axi_rresp,
	input wire logic [0:0]      s_axi_rvalid,
	input wire logic [0:0]      s_axi_rready,
	input wire logic [CH_N-1:0] pwm_out,
	input wire logic [0:0]      irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	// ========================================
	// steps of a transfer, and the reset release
	sequence aw_take;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rst_gone;
		$rose(rst_b);
	endsequence
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("write answer dropped early");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
	a_aw_ready_pulse: assert property (s_axi_awready && clk_en |=>
		!s_axi_awready) else $error("awready held two cycles");
	a_wr_answer: assert property (aw_take |-> ##[1:4] s_axi_bvalid)
		else $error("no write answer");
	a_rd_answer: assert property (ar_take |=> s_axi_rvalid)
		else $error("no read answer");
	a_rd_refused: assert property (ar_take ##0 s_axi_araddr[1:0] != 2'h0 |=>
		s_axi_rresp == fcpu_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("misaligned read not refused");
	a_rst_out_level: assert property (rst_gone |-> ##[1:4]
		pwm_out == {CH_N{reset_high_select}}) else $error("bad reset level");
	a_irq_rst_quiet: assert property (rst_gone |-> !irq [*4])
		else $error("irq after reset");
	a_freeze_hold: assert property (!clk_en |=> $stable(pwm_out))
		else $error("output moved while frozen");
endmodule
bind fcpu_top fcpu_top_chk #(.CH_N(CH_N)) fcpu_top_chk_inst (
	.clk_sys, .rst_b, .clk_en, .reset_high_select, .s_axi_awvalid,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .pwm_out, .irq
);

// *** test/testbench.sv ***
// Purpose: self-checking bench for the four channel pulse width unit
// Assumes: small periods keep the run short
// Notes: high time is summed over two periods, so phase does not matter
`timescale 1ns/1ps
`define CHK(a, b) begin \
	num_checks++; \
	if ((a) !== (b)) begin \
		n_fail++; \
		$display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); \
	end \
end
module testbench;
	localparam logic [7:0] CTRL = fcpu_pkg::IDX_CTRL;
	localparam logic [7:0] HI_IDX [4] = '{fcpu_pkg::IDX_CH0_HI,
		fcpu_pkg::IDX_CH1_HI, fcpu_pkg::IDX_CH2_HI, fcpu_pkg::IDX_CH3_HI};
	localparam logic [7:0] LO_IDX [4] = '{fcpu_pkg::IDX_CH0_LO,
		fcpu_pkg::IDX_CH1_LO, fcpu_pkg::IDX_CH2_LO, fcpu_pkg::IDX_CH3_LO};
	logic        clk_sys, rst_b, clk_en, reset_high_select, irq;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r0;
	logic [3:0]  s_axi_wstrb, pwm_out;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d0, d1;
	int          n_fail = 0, num_checks = 0, mp, mi, np, ninv, k, i;
	int          mc [4], nc [4], per_len [4];
	fcpu_top fcpu_top_inst (
		.clk_sys, .rst_b, .clk_en, .reset_high_select, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.pwm_out, .irq
	);
	fcpu_load_model fcpu_load_model_inst (.clk_sys, .pwm_out, .per_len);
	// ========================================
	// bus tasks, entered just after a rising edge
	task automatic wr(input logic [7:0] idx, input logic [7:0] v,
		input logic [1:0] er = fcpu_pkg::RESP_OKAY);
		s_axi_awaddr <= {2'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		`CHK(s_axi_bresp, er)
		s_axi_bready <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [1:0] lo,
		output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= {2'h0, idx, lo};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [7:0] e,
		input logic [1:0] lo = 2'h0,
		input logic [1:0] er = fcpu_pkg::RESP_OKAY);
		logic [31:0] d;
		logic [1:0]  r;
		rd(idx, lo, d, r);
		`CHK({r, d}, {er, 24'h0, e})
	endtask
	// ========================================
	// model: high samples over two periods against period and compare
	task automatic meas;
		int hc [4];
		int e;
		hc = '{default: 0};
		repeat (2 * (mp + 1)) begin
			@(posedge clk_sys);
			for (int j = 0; j < 4; j++) hc[j] += pwm_out[j];
		end
		for (int j = 0; j < 4; j++) begin
			e = (mc[j] > mp) ? 0 : 2 * (mp - mc[j] + 1);
			if (mi[j]) e = 2 * (mp + 1) - e;
			`CHK(hc[j], e)
			if (mc[j] != 0 && mc[j] <= mp) `CHK(per_len[j], mp + 1)
		end
	endtask
	// freeze a few cycles, then let the new settings reach steady state
	task automatic settle;
		clk_en <= 1'b0;
		repeat (3) @(posedge clk_sys);
		clk_en <= 1'b1;
		// the transfer may wait out one old period, 41 cycles at most
		repeat (3 * (mp + 1) + 41 + 8) @(posedge clk_sys);
	endtask
	task automatic close_out;
		if (n_fail == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_fail++;
		close_out();
	end
	initial begin
		rst_b <= 1'b0;
		clk_en <= 1'b1;
		reset_high_select <= 1'b0;
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
		s_axi_wstrb <= 4'hF;
		s_axi_awaddr <= 12'h0;
		s_axi_araddr <= 12'h0;
		s_axi_wdata <= 32'h0;
		void'($urandom(8327));
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk_sys);
		`CHK(pwm_out, 4'h0)
		repeat (2) @(posedge clk_sys);
		`CHK(pwm_out, 4'hF)
		`CHK(irq, 1'b0)
		rchk(fcpu_pkg::IDX_PER_HI, {6'h0, fcpu_pkg::PER_RST[9:8]});
		rchk(fcpu_pkg::IDX_PER_LO, fcpu_pkg::PER_RST[7:0]);
		rchk(CTRL, fcpu_pkg::CTRL_RST);
		for (i = 0; i < 4; i++) begin
			rchk(HI_IDX[i], {6'h0, fcpu_pkg::CMP_RST[9:8]});
			rchk(LO_IDX[i], fcpu_pkg::CMP_RST[7:0]);
		end
		rchk(8'hD0, 8'h00, 2'h0, fcpu_pkg::RESP_SLVERR);
		rchk(CTRL, 8'h00, 2'h1, fcpu_pkg::RESP_SLVERR);
		wr(8'hD0, 8'h55, fcpu_pkg::RESP_SLVERR);
		for (k = 0; k < 4; k++) begin
			np = $urandom_range(40, 8);
			ninv = $urandom_range(15, 0);
			for (i = 0; i < 4; i++) nc[i] = $urandom_range(np, 1);
			if (k == 3) begin
				nc[2] = 'h3FF;
				nc[3] = 0;
			end
			wr(fcpu_pkg::IDX_PER_HI, 8'(np >> 8));
			wr(fcpu_pkg::IDX_PER_LO, 8'(np));
			for (i = 0; i < 4; i++) begin
				wr(HI_IDX[i], 8'(nc[i] >> 8));
				wr(LO_IDX[i], 8'(nc[i]));
			end
			if (k > 0) meas();
			else wr(CTRL, 8'h10);
			wr(CTRL, 8'hC0 | 8'(ninv));
			mp = np;
			mi = ninv;
			mc = nc;
			settle();
			meas();
			rchk(CTRL, 8'hA0 | 8'(mi));
			rchk(CTRL, 8'h00, 2'h1, fcpu_pkg::RESP_SLVERR);
		end
		// stop first, keeping the flag, so an underflow cannot race the clear
		wr(CTRL, 8'h20 | 8'(mi));
		wr(CTRL, 8'(mi));
		rd(fcpu_pkg::IDX_COUNT, 2'h0, d0, r0);
		repeat (20) @(posedge clk_sys);
		rd(fcpu_pkg::IDX_COUNT, 2'h0, d1, r0);
		`CHK(d1, d0)
		rchk(CTRL, 8'(mi));
		wr(CTRL, 8'h10 | 8'(mi));
		rchk(fcpu_pkg::IDX_COUNT, 8'h00);
		rchk(CTRL, 8'(mi));
		rchk(fcpu_pkg::IDX_IRQ_ST, 8'h03);
		`CHK(irq, 1'b0)
		wr(fcpu_pkg::IDX_IRQ_MSK, 8'h01);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b1)
		wr(fcpu_pkg::IDX_IRQ_ST, 8'h03);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		rchk(fcpu_pkg::IDX_IRQ_ST, 8'h00);
		reset_high_select <= 1'b1;
		rst_b <= 1'b0;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (8) @(posedge clk_sys);
		`CHK(pwm_out, 4'hF)
		close_out();
	end
endmodule
